// *** hdl/fli_defines.svh ***
// constants of the fpu latency interlock: register ids, latencies, lock codes
// assumes nothing; included by the package and by every design file
`ifndef FLI_DEFINES_SVH
`define FLI_DEFINES_SVH

// register id space and latency width seen by the interlock
`define FLI_REG_W            7
`define FLI_LAT_W            5
`define FLI_FR_BASE          7'h10
`define FLI_ID_ACCUM_HIGH    7'h30
`define FLI_ID_ACCUM_LOW     7'h31
`define FLI_ID_FP_STATUS     7'h32
`define FLI_ID_FP_TRANSFER   7'h33
`define FLI_REG_ONE          7'h01

// slots of a result list, source operands and resource locks
`define FLI_SLOTS            5
`define FLI_SRCS             3
`define FLI_LOCKS            3

// branch latency
`define FLI_LAT_BR_COND      5'h02
`define FLI_LAT_BR_COND_ZERO 5'h01

// vector-matrix transform latencies, four vector elements then status
`define FLI_LAT_XFORM_0      5'h05
`define FLI_LAT_XFORM_1      5'h05
`define FLI_LAT_XFORM_2      5'h06
`define FLI_LAT_XFORM_3      5'h07
`define FLI_LAT_XFORM_ST     5'h08

// pair adjustments
`define FLI_LAT_FP_SHORTEN   5'h01
`define FLI_LAT_SHIFT_EXTRA  5'h01
`define FLI_LAT_LS_FLOOR     5'h03
`define FLI_LAT_MUL_PUSH     5'h05
`define FLI_LAT_MUL_CHAIN    5'h02
`define FLI_LAT_LDSACC_PUSH  5'h04
`define FLI_LAT_LDSACC_MUL   5'h01
`define FLI_LAT_TRUNC_MOVE   5'h01
`define FLI_LAT_ONE          5'h01
`define FLI_AGE_MAX          5'h1e

// resource locks
`define FLI_LOCK_WIN         32
`define FLI_LOCK_STAGES      3
`define FLI_LOCK_START_FIRST 5'h01

`endif

// *** hdl/fli_pkg.sv ***
// types of the fpu latency interlock: instruction descriptor and its parts
// assumes fli_defines.svh on the include path
`include "fli_defines.svh"
package fli_pkg;

  // how the result latency list maps onto destination registers
  typedef enum logic [2:0] {
    FLI_FMT_PLAIN  = 3'h0,
    FLI_FMT_DOUBLE = 3'h1,
    FLI_FMT_XFORM  = 3'h2,
    FLI_FMT_MAC    = 3'h3,
    FLI_FMT_MUL    = 3'h4
  } fli_fmt_type;

  typedef enum logic [1:0] {
    FLI_STG_FP_ZERO  = 2'h0,
    FLI_STG_FP_ONE   = 2'h1,
    FLI_STG_FP_THREE = 2'h2,
    FLI_STG_NONE     = 2'h3
  } fli_stage_type;

  typedef struct packed {
    logic fp_compute;
    logic fp_store;
    logic fp_integer_transfer_reg_move;
    logic fp_integer_transfer_reg_push;
    logic load;
    logic dyn_shift;
    logic ls_group;
    logic fp_heavy;
    logic mult;
    logic accum_push;
    logic lds_accum;
    logic fp_toggle;
    logic trunc_single;
    logic fp_reg_access;
    logic branch;
    logic cond_branch;
    logic disp_zero;
  } fli_flags_type;

  typedef struct packed {
    fli_stage_type          stage;
    logic [`FLI_LAT_W-1:0]  start;
    logic [`FLI_LAT_W-1:0]  cycles;
  } fli_lock_type;

  typedef struct packed {
    logic                                          valid;
    logic                                          tag;
    fli_flags_type                                 flags;
    fli_fmt_type                                   fmt;
    logic [`FLI_SRCS-1:0]                          src_en;
    logic [`FLI_SRCS-1:0][`FLI_REG_W-1:0]          src;
    logic [`FLI_REG_W-1:0]                         dst_base;
    logic [`FLI_REG_W-1:0]                         dst_aux;
    logic [`FLI_SLOTS-1:0][`FLI_REG_W-1:0]         dst_plain;
    logic [`FLI_SLOTS-1:0]                         lat_en;
    logic [`FLI_SLOTS-1:0][`FLI_LAT_W-1:0]         lat;
    fli_lock_type [`FLI_LOCKS-1:0]                 locks;
  } fli_instr_type;

endpackage

// *** hdl/fli_lock_unit.sv ***
// stage occupancy map for the floating-point resource locks
// assumes an asynchronous active-low reset already released cleanly upstream
`timescale 1ns/100ps
`include "fli_defines.svh"
module fli_lock_unit #(
  parameter int WIN    = `FLI_LOCK_WIN,
  parameter int STAGES = `FLI_LOCK_STAGES
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_b_in,
  input  wire logic                                issue_in,
  input  wire fli_pkg::fli_lock_type [`FLI_LOCKS-1:0] locks_in,
  output logic                                     conflict_out,
  output logic [STAGES-1:0]                        busy_out
);

  // bit k of a row means the stage is held k cycles from now
  logic [STAGES-1:0][WIN-1:0] occ_r;
  logic [STAGES-1:0][WIN-1:0] occ_nxt;
  logic [STAGES-1:0][WIN-1:0] need;
  logic [STAGES-1:0]          clash;

  function automatic logic [WIN-1:0] win_mask(input logic [`FLI_LAT_W-1:0] start,
                                              input logic [`FLI_LAT_W-1:0] cycles);
    logic [WIN:0]           ones;
    logic [`FLI_LAT_W-1:0]  ofs;
    ones = ({{WIN{1'b0}}, 1'b1} << cycles) - {{WIN{1'b0}}, 1'b1};
    // start 1 is the issue cycle itself
    ofs  = (start < `FLI_LOCK_START_FIRST) ? 5'h00 : start - `FLI_LOCK_START_FIRST;
    return ones[WIN-1:0] << ofs; // RQ8
  endfunction

  genvar s;
  generate
    for (s = 0; s < STAGES; s++) begin : g_stage
      always_comb begin
        need[s] = '0;
        for (int k = 0; k < `FLI_LOCKS; k++) begin
          if (locks_in[k].stage == fli_pkg::fli_stage_type'(s)) begin
            need[s] = need[s] | win_mask(locks_in[k].start, locks_in[k].cycles);
          end
        end
      end
      assign clash[s]   = |(need[s] & occ_r[s]); // RQ8
      // the issue cycle itself is consumed at this edge, so shift after merging
      assign occ_nxt[s] = issue_in ? ((occ_r[s] | need[s]) >> 1) : (occ_r[s] >> 1); // RQ9
      assign busy_out[s] = occ_r[s][0];
    end
  endgenerate

  assign conflict_out = |clash;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      occ_r <= '0;
    end else begin
      occ_r <= occ_nxt;
    end
  end

endmodule

// *** hdl/fli_latency_interlock.sv ***
// issue interlock between decode and the integer and fp execution units
// assumes decode holds one descriptor on instr_in and flips its tag per new instruction
`timescale 1ns/100ps
`include "fli_defines.svh"

// What this block does
// RQ1 - every written register, accumulators and fp status included, keeps its own latency
// RQ2 - branch latency counts until the branch target instruction is fetched
// RQ3 - conditional branch latency is 2, or 1 for a zero displacement
// RQ4 - double precision latencies go to odd register, even register, then fp status
// RQ5 - transform results ready after 5, 5, 6, 7 cycles; fp status after 8
// RQ6 - multiply-accumulate latencies go to both pointers, accumulator high, accumulator low
// RQ7 - plain multiply latencies go to accumulator high then accumulator low
// RQ8 - a lock holds one stage from a start cycle, 1 meaning first decode cycle
// RQ9 - a lock lasts exactly its cycle count from its start, then releases
// RQ10 - fp computation followed by fp store or transfer move/push: one cycle shorter
// RQ11 - load feeding the shift amount of a dynamic shift: one cycle longer
// RQ12 - short load/store-group result before double, inner product or transform: raised to 3
// RQ13 - multiply followed by an accumulator push: latency 5
// RQ14 - back to back multiplies: latency 2 between them
// RQ15 - accumulator load followed by that accumulator's push: latency 4
// RQ16 - accumulator load followed by a multiply: latency 1
// RQ17 - after an fp size or bank toggle, an fp load/store is issued alone
// RQ18 - single float-to-int truncation followed by a transfer move: latency 1
// RQ19 - hold an instruction until its sources and stages clear, then issue at once
module fli_latency_interlock #(
  parameter int LOCK_WIN = `FLI_LOCK_WIN
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_b_in,
  input  wire fli_pkg::fli_instr_type    instr_in,
  output logic                           issue_out,
  output logic                           issue_tag_out,
  output logic                           issue_solo_out,
  output logic                           stall_out,
  output logic                           fetch_target_out,
  output logic [`FLI_LOCK_STAGES-1:0]    stage_busy_out
);

  localparam int NREG = 2 ** `FLI_REG_W;
  localparam int NS   = `FLI_SLOTS;

  logic rst_meta_r;
  logic rst_sync_r;

  fli_pkg::fli_instr_type ins;

  // destinations of the instruction in decode
  logic [NS-1:0][`FLI_REG_W-1:0] cur_id;
  logic [NS-1:0]                 cur_en;
  logic [NS-1:0][`FLI_LAT_W-1:0] cur_lat;

  // scoreboard, one down counter per register
  logic [`FLI_LAT_W-1:0] cnt_r   [NREG];
  logic [`FLI_LAT_W-1:0] cnt_nxt [NREG];

  // the instruction issued last, for pair adjustments
  fli_pkg::fli_flags_type        prev_flags_r;
  logic [NS-1:0][`FLI_REG_W-1:0] prev_id_r;
  logic [NS-1:0]                 prev_en_r;
  logic [NS-1:0][`FLI_LAT_W-1:0] prev_lat_r;
  logic [`FLI_LAT_W-1:0]         age_r;
  logic [`FLI_LAT_W-1:0]         age_nxt;
  logic [`FLI_LAT_W-1:0]         age_inc;

  logic                  br_pend_r;
  logic [`FLI_LAT_W-1:0] br_cnt_r;
  logic [`FLI_LAT_W-1:0] br_lat;
  logic                  br_busy;

  logic src_hazard;
  logic lock_conflict;
  logic fresh;
  logic go;
  logic solo;

  logic                  issue_r;
  logic                  tag_r;
  logic                  solo_r;
  logic                  stall_r;
  logic                  fetch_r;

  function automatic logic is_accum(input logic [`FLI_REG_W-1:0] id);
    return (id == `FLI_ID_ACCUM_HIGH) || (id == `FLI_ID_ACCUM_LOW);
  endfunction

  function automatic logic [`FLI_REG_W-1:0] dest_id(input fli_pkg::fli_instr_type i,
                                                     input int slot);
    logic [`FLI_REG_W-1:0] id;
    id = i.dst_plain[slot];
    unique case (i.fmt)
      fli_pkg::FLI_FMT_PLAIN: id = i.dst_plain[slot];
      fli_pkg::FLI_FMT_DOUBLE: begin
        // odd half first, then even half, then status
        if (slot == 0)      id = i.dst_base + `FLI_REG_ONE; // RQ4
        else if (slot == 1) id = i.dst_base; // RQ4
        else                id = `FLI_ID_FP_STATUS; // RQ4
      end
      fli_pkg::FLI_FMT_XFORM: begin
        if (slot == NS - 1) id = `FLI_ID_FP_STATUS; // RQ5
        else                id = i.dst_base + `FLI_REG_W'(slot); // RQ5
      end
      fli_pkg::FLI_FMT_MAC: begin
        if (slot == 0)      id = i.dst_base; // RQ6
        else if (slot == 1) id = i.dst_aux; // RQ6
        else if (slot == 2) id = `FLI_ID_ACCUM_HIGH; // RQ6
        else                id = `FLI_ID_ACCUM_LOW; // RQ6
      end
      fli_pkg::FLI_FMT_MUL: begin
        if (slot == 0) id = `FLI_ID_ACCUM_HIGH; // RQ7
        else           id = `FLI_ID_ACCUM_LOW; // RQ7
      end
      default: id = i.dst_plain[slot];
    endcase
    return id;
  endfunction

  // the transform's latencies are fixed here rather than trusted from decode
  function automatic logic [`FLI_LAT_W-1:0] base_lat(input fli_pkg::fli_instr_type i,
                                                     input int slot);
    logic [`FLI_LAT_W-1:0] l;
    l = i.lat[slot];
    if (i.fmt == fli_pkg::FLI_FMT_XFORM) begin
      unique case (slot)
        0:       l = `FLI_LAT_XFORM_0; // RQ5
        1:       l = `FLI_LAT_XFORM_1; // RQ5
        2:       l = `FLI_LAT_XFORM_2; // RQ5
        3:       l = `FLI_LAT_XFORM_3; // RQ5
        default: l = `FLI_LAT_XFORM_ST; // RQ5
      endcase
    end
    return l;
  endfunction

  // latency of one earlier result as seen by the very next instruction;
  // later checks override earlier ones where two exceptions meet
  function automatic logic [`FLI_LAT_W-1:0] adj_lat(input fli_pkg::fli_flags_type p,
                                                    input logic [`FLI_REG_W-1:0] id,
                                                    input logic [`FLI_LAT_W-1:0] base,
                                                    input fli_pkg::fli_flags_type c);
    logic [`FLI_LAT_W-1:0] l;
    l = base;
    if (p.load && c.dyn_shift) l = base + `FLI_LAT_SHIFT_EXTRA; // RQ11
    if (p.ls_group && c.fp_heavy && (base < `FLI_LAT_LS_FLOOR)) begin
      l = `FLI_LAT_LS_FLOOR; // RQ12
    end
    if (p.fp_compute && (c.fp_store || c.fp_integer_transfer_reg_move || c.fp_integer_transfer_reg_push) &&
        (base > `FLI_LAT_FP_SHORTEN)) begin
      l = base - `FLI_LAT_FP_SHORTEN; // RQ10
    end
    if (p.trunc_single && c.fp_integer_transfer_reg_move) l = `FLI_LAT_TRUNC_MOVE; // RQ18
    if (is_accum(id)) begin
      if (p.mult && c.mult)            l = `FLI_LAT_MUL_CHAIN; // RQ14
      if (p.mult && c.accum_push)      l = `FLI_LAT_MUL_PUSH; // RQ13
      if (p.lds_accum && c.accum_push) l = `FLI_LAT_LDSACC_PUSH; // RQ15
      if (p.lds_accum && c.mult)       l = `FLI_LAT_LDSACC_MUL; // RQ16
    end
    return l;
  endfunction

  assign ins = instr_in;

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_slot
      assign cur_id[g]  = dest_id(ins, g); // RQ1
      assign cur_en[g]  = (ins.fmt == fli_pkg::FLI_FMT_XFORM) ? 1'b1 : ins.lat_en[g];
      assign cur_lat[g] = base_lat(ins, g);
    end
  endgenerate

  // a source written by the previous instruction waits on its adjusted
  // latency counted from that issue; any other source waits on its counter
  always_comb begin
    src_hazard = 1'b0;
    for (int i = 0; i < `FLI_SRCS; i++) begin
      logic hit;
      hit = 1'b0;
      if (ins.src_en[i]) begin
        for (int j = 0; j < NS; j++) begin
          if (prev_en_r[j] && (prev_id_r[j] == ins.src[i])) begin
            hit = 1'b1;
            if (age_inc < adj_lat(prev_flags_r, prev_id_r[j], prev_lat_r[j], ins.flags)) begin
              src_hazard = 1'b1; // RQ1
            end
          end
        end
        if (!hit && (cnt_r[ins.src[i]] != '0)) src_hazard = 1'b1; // RQ1
      end
    end
  end

  assign age_inc = age_r + `FLI_LAT_ONE;
  assign age_nxt = go ? '0 : ((age_r < `FLI_AGE_MAX) ? age_inc : age_r);

  // the target cannot issue before it has been fetched
  assign br_lat  = ins.flags.cond_branch ?
                   (ins.flags.disp_zero ? `FLI_LAT_BR_COND_ZERO : `FLI_LAT_BR_COND) : // RQ3
                   ins.lat[0];
  assign br_busy = br_pend_r; // RQ2

  assign fresh = ins.valid && (ins.tag != tag_r);
  assign go    = fresh && !src_hazard && !lock_conflict && !br_busy; // RQ19
  assign solo  = go && prev_flags_r.fp_toggle && ins.flags.ls_group &&
                 ins.flags.fp_reg_access; // RQ17

  fli_lock_unit #(
    .WIN    (LOCK_WIN),
    .STAGES (`FLI_LOCK_STAGES)
  ) u_lock (
    .clk_in       (ref_clk_in),
    .rst_b_in     (rst_sync_r),
    .issue_in     (go), // RQ9
    .locks_in     (ins.locks),
    .conflict_out (lock_conflict), // RQ8
    .busy_out     (stage_busy_out)
  );

  // counter holds latency minus one after the issuing edge, so a reader
  // issues exactly latency cycles after the writer
  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      cnt_nxt[r] = (cnt_r[r] == '0) ? '0 : cnt_r[r] - `FLI_LAT_ONE;
      for (int s = 0; s < NS; s++) begin
        if (go && cur_en[s] && (cur_id[s] == `FLI_REG_W'(r))) begin
          cnt_nxt[r] = (cur_lat[s] == '0) ? '0 : cur_lat[s] - `FLI_LAT_ONE; // RQ1
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      for (int r = 0; r < NREG; r++) cnt_r[r] <= '0;
    end else begin
      for (int r = 0; r < NREG; r++) cnt_r[r] <= cnt_nxt[r];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      prev_flags_r <= '0;
      prev_id_r    <= '0;
      prev_en_r    <= '0;
      prev_lat_r   <= '0;
      age_r        <= '0;
    end else begin
      age_r <= age_nxt;
      if (go) begin
        prev_flags_r <= ins.flags;
        prev_id_r    <= cur_id;
        prev_en_r    <= cur_en;
        prev_lat_r   <= cur_lat;
      end
    end
  end

  // pulse one cycle after the counter runs out, which is the fetch cycle
  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      br_pend_r <= 1'b0;
      br_cnt_r  <= '0;
      fetch_r   <= 1'b0;
    end else begin
      fetch_r <= 1'b0;
      if (go && ins.flags.branch) begin
        if (br_lat <= `FLI_LAT_ONE) begin
          fetch_r <= 1'b1; // RQ2
        end else begin
          br_pend_r <= 1'b1;
          br_cnt_r  <= br_lat - 5'h02;
        end
      end else if (br_pend_r) begin
        if (br_cnt_r == '0) begin
          br_pend_r <= 1'b0;
          fetch_r   <= 1'b1; // RQ2
        end else begin
          br_cnt_r <= br_cnt_r - `FLI_LAT_ONE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      issue_r <= 1'b0;
      tag_r   <= 1'b0;
      solo_r  <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      issue_r <= go;
      solo_r  <= solo;
      stall_r <= fresh && !go; // RQ19
      if (go) tag_r <= ins.tag;
    end
  end

  assign issue_out        = issue_r;
  assign issue_tag_out    = tag_r;
  assign issue_solo_out   = solo_r;
  assign stall_out        = stall_r;
  assign fetch_target_out = fetch_r;

endmodule

// *** tb/fli_latency_interlock_asserts.sv ***
// port checker for the fpu latency interlock
// assumes a bind onto fli_latency_interlock, one clock domain
`timescale 1ns/100ps
`include "fli_defines.svh"
module fli_latency_interlock_asserts #(
  parameter int LOCK_WIN = `FLI_LOCK_WIN
) (
  input wire logic                        ref_clk_in,
  input wire logic                        rst_b_in,
  input wire fli_pkg::fli_instr_type      instr_in,
  input wire logic                        issue_out,
  input wire logic                        issue_tag_out,
  input wire logic                        issue_solo_out,
  input wire logic                        stall_out,
  input wire logic                        fetch_target_out,
  input wire logic [`FLI_LOCK_STAGES-1:0] stage_busy_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // saturates, so a long idle spell never looks like a recent issue
  logic [5:0] since_r;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      since_r <= 6'h3f;
    else if (issue_out)
      since_r <= 6'h00;
    else if (since_r != 6'h3f)
      since_r <= since_r + 6'h01;
  end
  a_issue_taken: assert property (
    issue_out |-> $past(instr_in.valid) && issue_tag_out == $past(instr_in.tag)
      && $past(instr_in.tag) != $past(issue_tag_out))
    else $error("issue without a fresh valid instruction");
  a_tag_idle: assert property (!issue_out |-> $stable(issue_tag_out))
    else $error("issued tag moved without an issue");
  a_stall_fresh: assert property (
    stall_out |-> !issue_out && $past(instr_in.valid)
      && $past(instr_in.tag) != $past(issue_tag_out))
    else $error("stall without a held fresh instruction");
  a_solo_issue: assert property (issue_solo_out |-> issue_out)
    else $error("solo flag without an issue");
  a_solo_cause: assert property (
    issue_solo_out |-> $past(instr_in.flags.ls_group) && $past(instr_in.flags.fp_reg_access))
    else $error("solo flag on an instruction without fp access");
  a_cond_far: assert property (
    issue_out && $past(instr_in.flags.cond_branch) && !$past(instr_in.flags.disp_zero)
      |-> !fetch_target_out ##1 (fetch_target_out && !issue_out))
    else $error("far conditional branch fetch timing wrong");
  a_cond_near: assert property (
    issue_out && $past(instr_in.flags.cond_branch) && $past(instr_in.flags.disp_zero)
      |-> fetch_target_out)
    else $error("near conditional branch fetch timing wrong");
  a_busy_bound: assert property (
    |stage_busy_out |-> issue_out || since_r < LOCK_WIN)
    else $error("stage lock outlived its window");
  c_stall: cover property (stall_out ##1 issue_out);
  c_solo: cover property (issue_solo_out);
  c_fetch: cover property (fetch_target_out && !issue_out);
  c_busy: cover property (|stage_busy_out);
endmodule
bind fli_latency_interlock fli_latency_interlock_asserts #(
  .LOCK_WIN(LOCK_WIN)
) u_fli_chk (
  .ref_clk_in      (ref_clk_in),
  .rst_b_in        (rst_b_in),
  .instr_in        (instr_in),
  .issue_out       (issue_out),
  .issue_tag_out   (issue_tag_out),
  .issue_solo_out  (issue_solo_out),
  .stall_out       (stall_out),
  .fetch_target_out(fetch_target_out),
  .stage_busy_out  (stage_busy_out)
);

// *** tb/fli_latency_interlock_tb_top.sv ***
// self-checking bench for the fpu latency interlock
// assumes the design package and defines are compiled first
`timescale 1ns/100ps
`include "fli_defines.svh"
module fli_latency_interlock_tb_top;
  logic                        ref_clk_in;
  logic                        rst_b_in;
  fli_pkg::fli_instr_type      instr_in;
  logic                        issue_out;
  logic                        issue_tag_out;
  logic                        issue_solo_out;
  logic                        stall_out;
  logic                        fetch_target_out;
  logic [`FLI_LOCK_STAGES-1:0] stage_busy_out;
  int                          n_errors = 0;
  int                          samples_checked = 0;
  int                          cyc = 0;
  int                          last_issue = 0;
  int                          gap;
  int                          s;
  int                          st;
  int                          c;
  int                          stalls;
  int                          busy_cnt [3];
  logic                        solo_seen;
  logic [6:0]                  r;
  logic [6:0]                  q;
  logic [4:0]                  l;
  fli_pkg::fli_instr_type      p;
  // pair table: producer flags, dest, latency; follower flags, source; gap
  localparam logic [16:0] PF [9] = '{17'h1_0000, 17'h1_0000, 17'h0_1000, 17'h0_0400,
    17'h0_0100, 17'h0_0100, 17'h0_0040, 17'h0_0040, 17'h1_0010};
  localparam logic [6:0]  PR [9] = '{7'h13, 7'h33, 7'h02, 7'h13, 7'h00, 7'h00, 7'h30,
    7'h31, 7'h33};
  localparam logic [4:0]  PL [9] = '{5'h04, 5'h04, 5'h02, 5'h01, 5'h03, 5'h04, 5'h03,
    5'h03, 5'h04};
  localparam logic [16:0] FF [9] = '{17'h0_8000, 17'h0_2000, 17'h0_0800, 17'h0_0200,
    17'h0_0080, 17'h0_0100, 17'h0_0080, 17'h0_0100, 17'h0_4000};
  localparam logic [6:0]  FS [9] = '{7'h13, 7'h33, 7'h02, 7'h13, 7'h30, 7'h31, 7'h30,
    7'h31, 7'h33};
  // decode presents only after seeing issue_out, so no gap is below 2
  localparam int          EX [9] = '{3, 3, 3, 3, 5, 2, 4, 2, 2};
  // multi-result table: format, register read back, gap
  localparam logic [2:0]  MF [12] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
    3'h4, 3'h4, 3'h3, 3'h3};
  localparam logic [6:0]  MR [12] = '{7'h15, 7'h14, 7'h32, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h32, 7'h30, 7'h31, 7'h30, 7'h31};
  localparam int          ME [12] = '{3, 4, 5, 5, 5, 6, 7, 8, 3, 4, 5, 6};

  fli_latency_interlock DUT (
    .ref_clk_in      (ref_clk_in),
    .rst_b_in        (rst_b_in),
    .instr_in        (instr_in),
    .issue_out       (issue_out),
    .issue_tag_out   (issue_tag_out),
    .issue_solo_out  (issue_solo_out),
    .stall_out       (stall_out),
    .fetch_target_out(fetch_target_out),
    .stage_busy_out  (stage_busy_out)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 3; k++)
      if (stage_busy_out[k] === 1'b1)
        busy_cnt[k] <= busy_cnt[k] + 1;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_int(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic fli_pkg::fli_instr_type op(input logic [16:0] fl);
    fli_pkg::fli_instr_type d;
    d = '0;
    d.valid = 1'b1;
    d.flags = fli_pkg::fli_flags_type'(fl);
    for (int k = 0; k < `FLI_LOCKS; k++)
      d.locks[k].stage = fli_pkg::FLI_STG_NONE;
    return d;
  endfunction

  function automatic fli_pkg::fli_instr_type wr(input logic [16:0] fl,
                                                input logic [6:0] id, input logic [4:0] lt);
    fli_pkg::fli_instr_type d;
    d = op(fl);
    d.dst_plain[0] = id;
    d.lat_en[0] = 1'b1;
    d.lat[0] = lt;
    return d;
  endfunction

  function automatic fli_pkg::fli_instr_type rd(input logic [16:0] fl, input logic [6:0] id);
    fli_pkg::fli_instr_type d;
    d = op(fl);
    d.src_en[0] = 1'b1;
    d.src[0] = id;
    return d;
  endfunction

  // presented one cycle after the previous issue pulse is seen, so gap equals a latency of 2 or more
  task automatic put(input fli_pkg::fli_instr_type d);
    int w;
    @(negedge ref_clk_in);
    d.tag = ~issue_tag_out;
    instr_in = d;
    w = 0;
    stalls = 0;
    @(negedge ref_clk_in);
    while (issue_out !== 1'b1 && w < 60) begin
      stalls += (stall_out === 1'b1);
      @(negedge ref_clk_in);
      w++;
    end
    chk_bit(issue_tag_out, d.tag);
    solo_seen = issue_solo_out;
    gap = cyc - last_issue;
    last_issue = cyc;
  endtask

  task automatic settle();
    repeat (40) @(negedge ref_clk_in);
  endtask

  initial begin
    instr_in = '0;
    rst_b_in = 1'b0;
    busy_cnt = '{0, 0, 0};
    void'($urandom(32'he70e));
    repeat (10) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    for (int i = 0; i < 40; i++) begin
      r = 7'($urandom_range(15, 1));
      l = 5'($urandom_range(9, 2));
      q = $urandom_range(1, 0) ? r : r ^ 7'h10;
      settle();
      put(wr(17'h0_0000, r, l));
      put(rd(17'h0_0000, q));
      chk_int(gap, (q == r) ? int'(l) : 2);
      chk_int(stalls, ((q == r) ? int'(l) : 2) - 2);
    end
    for (int i = 0; i < 12; i++) begin
      p = op(17'h0_0000);
      p.fmt = fli_pkg::fli_fmt_type'(MF[i]);
      p.dst_base = 7'h14;
      // only the slots that the format really has may carry a latency
      p.lat_en = (MF[i] == 3'h1) ? 5'h07 : (MF[i] == 3'h3) ? 5'h0f :
                 (MF[i] == 3'h4) ? 5'h03 : 5'h1f;
      for (int k = 0; k < 5; k++)
        p.lat[k] = 5'(k + 3);
      settle();
      put(p);
      put(rd(17'h0_0000, MR[i]));
      chk_int(gap, ME[i]);
    end
    for (int i = 0; i < 9; i++) begin
      p = wr(PF[i], PR[i], PL[i]);
      if (PF[i][8]) begin
        p.fmt = fli_pkg::FLI_FMT_MUL;
        p.lat_en = 5'h03;
        p.lat[1] = PL[i];
      end
      settle();
      put(p);
      put(rd(FF[i], FS[i]));
      chk_int(gap, EX[i]);
    end
    for (int i = 0; i < 4; i++) begin
      settle();
      put(op(i[0] ? 17'h0_0000 : 17'h0_0020));
      put(op(i[1] ? 17'h0_0400 : 17'h0_0408));
      chk_bit(solo_seen, ~i[0] & ~i[1]);
    end
    for (int i = 0; i < 2; i++) begin
      settle();
      put(op(17'h0_0006 | 17'(i)));
      chk_bit(fetch_target_out, i[0]);
      @(negedge ref_clk_in);
      chk_bit(fetch_target_out, ~i[0]);
      put(op(17'h0_0000));
      chk_int(gap, 3);
    end
    for (int i = 0; i < 8; i++) begin
      s = $urandom_range(2, 0);
      st = (i == 0) ? 1 : $urandom_range(4, 1);
      c = (i == 0) ? 1 : (i == 1) ? 8 : $urandom_range(8, 1);
      p = op(17'h0_0000);
      p.locks[0] = '{fli_pkg::fli_stage_type'(2'(s)), 5'(st), 5'(c)};
      settle();
      busy_cnt = '{0, 0, 0};
      put(p);
      p.locks[0] = '{fli_pkg::fli_stage_type'(2'(s)), 5'h01, 5'h01};
      put(p);
      // a lock starting after the follower's first chance does not hold it
      chk_int(gap, (st > 3 || st + c < 3) ? 2 : st + c - 1);
      settle();
      // busy is registered, so the decision cycle itself never shows
      chk_int(busy_cnt[s], (st == 1) ? c - 1 : c);
    end
    final_report();
  end
endmodule
